// ==== bpwm_pkg.sv ====
`default_nettype none
package bpwm_pkg;
  // Byte addresses of the two registers
  localparam logic [19:0] CTRL_OFS = 20'h6_1350;
  localparam logic [19:0] PWM_OFS = 20'h6_1354;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] PWM_RST = 32'h0000_0000;
  // Control word field positions
  localparam int EN_BIT = 31;
  localparam int POL_BIT = 28;
  localparam int STAT_BIT = 26;
  localparam int START_BIT = 25;
  localparam int IEN_BIT = 24;
  localparam int TB_LSB = 16;
  localparam int CNT_LSB = 8;
  localparam int INC_LSB = 0;
  // Period and duty field positions
  localparam int PER_LSB = 16;
  localparam int DUTY_LSB = 0;
  // Input clock cycles per time-base event
  localparam int CORE_DIV = 128;
  localparam int LP_DIV = 16;
  // Clock rate of pclk
  localparam int PCLK_HZ = 25000000;

  // Phase-in control fields as one carrier
  typedef struct packed {
    logic enable;
    logic polarity;
    logic status;
    logic start;
    logic irq_en;
    logic [7:0] timebase;
    logic [7:0] count;
    logic [7:0] incr;
  } ctrl_type;

  // Phase-in sequencer states
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_WAIT = 3'b010,
    PH_END = 3'b100
  } phase_state_type;
endpackage
`default_nettype wire

// ==== bpwm_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
// Time-base event generator: one pulse per CORE_DIV or LP_DIV clocks
module bpwm_tick #(
  parameter int W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lp_sel,
  output logic tick
);
  // Prescaler must hold the divide-by-128 terminal count
  if (W < 7) begin : g_w_check
    $error("bpwm_tick: W too small for divide by 128");
  end

  logic [W-1:0] cnt_q; // Free-running prescaler
  logic [W-1:0] last; // Terminal count for the chosen source

  // The low-power source divides by 16, the core source by 128
  assign last = lp_sel ? W'(bpwm_pkg::LP_DIV - 1) : W'(bpwm_pkg::CORE_DIV - 1);
  assign tick = (cnt_q >= last);

  // Wrap at terminal count; a count already past a newly lowered terminal wraps at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end
endmodule
`default_nettype wire

// ==== bpwm_core.sv ====
`timescale 1ns/1ps
`default_nettype none
// Period counter, duty shadow and output stage
module bpwm_core #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic enable,
  input wire logic polarity,
  input wire logic [W-1:0] period,
  input wire logic [W-1:0] duty,
  output logic raw,
  output logic pwm_out,
  output logic [W-1:0] duty_live,
  output logic wrap
);
  // Counter and compare need at least one bit
  if (W < 1) begin : g_w_check
    $error("bpwm_core: W must be at least one");
  end

  logic [W-1:0] cnt_q; // Events elapsed in this cycle
  logic [W-1:0] shadow_q; // Duty in force for this cycle
  logic raw_q; // Raw modulated level
  logic out_q; // Level after polarity

  // Cycle ends on the event that reaches the period
  assign wrap = tick && ({1'b0, cnt_q} + (W+1)'(1) >= {1'b0, period});
  assign raw = raw_q;
  assign pwm_out = out_q;
  assign duty_live = shadow_q;

  // Counter held at zero while disabled so a restart is clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!enable || wrap) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  // Shadow reloads at the cycle boundary, and follows duty on every clock while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_q <= '0;
    end else if (!enable || wrap) begin
      shadow_q <= duty;
    end
  end

  // Active while count below duty; raw level zero when disabled, output then equals polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      raw_q <= enable && (cnt_q < shadow_q);
      out_q <= (enable && (cnt_q < shadow_q)) ^ polarity;
    end
  end

  // Full duty in force keeps the output active; a count left above a shrunk period is excluded
  AST_DUTY_FULL: assert property (@(posedge pclk) disable iff (!presetn)
    (enable && shadow_q == period && cnt_q < period) |=> raw)
    else $error("output inactive with full duty");
endmodule
`default_nettype wire

// ==== backlight_pwm_phase_in.sv ====
`timescale 1ns/1ps
`default_nettype none
// Backlight modulator with vblank-paced duty phase-in
module backlight_pwm_phase_in #(
  parameter int AW = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vblank,
  input wire logic low_power_idle_clock,
  output logic backlight_pwm,
  output logic phase_in_irq
);
  // The highest register offset needs nineteen address bits
  if (AW < 19) begin : g_aw_check
    $error("backlight_pwm_phase_in: AW cannot reach the map");
  end

  // Word-aligned match against one register offset
  function automatic logic hit(input logic [AW-1:0] a, input logic [19:0] ofs);
    hit = (a[AW-1:2] == (AW-2)'(AW'(ofs) >> 2));
  endfunction

  bpwm_pkg::ctrl_type ctrl_q; // Phase-in and output control
  logic [15:0] period_q; // Events per PWM cycle
  logic [15:0] duty_q; // Programmed or stepped duty
  bpwm_pkg::phase_state_type state_q; // Sequencer state
  logic [7:0] vb_cnt_q; // Vblanks seen since last step
  logic vblank_q; // Previous vblank level
  logic [31:0] prdata_q; // Read data captured at setup

  logic acc; // Access phase of any transfer
  logic hit_ctrl; // Address selects control word
  logic hit_pwm; // Address selects period and duty
  logic wr_ctrl; // Control word written this edge
  logic wr_pwm; // Period and duty written this edge
  logic vb_edge; // Start of a vertical blank
  logic inc_ev; // One increment event
  logic done_ev; // Final increment of the sequence
  logic [17:0] sum; // Duty plus signed increment
  logic [15:0] stepped; // Sum kept inside 0..period
  logic tick; // Time-base event
  logic raw; // Raw level before polarity
  logic [15:0] duty_live; // Duty in force this cycle
  logic wrap; // End of a PWM cycle

  // Zero-wait slave: every access completes in its first cycle
  assign acc = psel && penable;
  assign hit_ctrl = hit(paddr, bpwm_pkg::CTRL_OFS);
  assign hit_pwm = hit(paddr, bpwm_pkg::PWM_OFS);
  assign wr_ctrl = acc && pwrite && hit_ctrl;
  assign wr_pwm = acc && pwrite && hit_pwm;
  assign pready = 1'b1;
  assign pslverr = acc && !hit_ctrl && !hit_pwm;
  assign prdata = prdata_q;
  assign phase_in_irq = ctrl_q.status;

  // A vblank event is the rising edge of the blank level
  assign vb_edge = vblank && !vblank_q;

  // Step falls due when this blank completes the time base
  assign inc_ev = (state_q == bpwm_pkg::PH_WAIT) && vb_edge
    && ({1'b0, vb_cnt_q} + 9'(1) == {1'b0, ctrl_q.timebase});
  assign done_ev = inc_ev && (ctrl_q.count == 8'h01);

  // Signed step, clamped so a long ramp cannot wrap the duty
  always_comb begin
    sum = {2'b00, duty_q} + {{10{ctrl_q.incr[7]}}, ctrl_q.incr};
    if (sum[17]) begin
      stepped = '0;
    end else if (sum[16:0] > {1'b0, period_q}) begin
      stepped = period_q;
    end else begin
      stepped = sum[15:0];
    end
  end

  // Time base from the core clock or the low-power clock
  bpwm_tick #(
    .W(7)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .lp_sel(low_power_idle_clock),
    .tick(tick)
  );

  // Counter, duty shadow and polarity stage
  bpwm_core #(
    .W(16)
  ) u_core (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .enable(ctrl_q.enable),
    .polarity(ctrl_q.polarity),
    .period(period_q),
    .duty(duty_q),
    .raw(raw),
    .pwm_out(backlight_pwm),
    .duty_live(duty_live),
    .wrap(wrap)
  );

  // Read data is sampled in the setup cycle, so live fields are one cycle old
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (hit(paddr, bpwm_pkg::CTRL_OFS)) begin
        prdata_q <= {ctrl_q.enable, 2'b00, ctrl_q.polarity, 1'b0, ctrl_q.status,
          ctrl_q.start, ctrl_q.irq_en, ctrl_q.timebase, ctrl_q.count, ctrl_q.incr};
      end else if (hit(paddr, bpwm_pkg::PWM_OFS)) begin
        prdata_q <= {period_q, duty_q};
      end else begin
        prdata_q <= '0; // Unmapped reads return zero
      end
    end
  end

  // Previous vblank level for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vblank_q <= 1'b0;
    end else begin
      vblank_q <= vblank;
    end
  end

  // Plain control fields follow software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q.enable <= bpwm_pkg::CTRL_RST[bpwm_pkg::EN_BIT];
      ctrl_q.polarity <= bpwm_pkg::CTRL_RST[bpwm_pkg::POL_BIT];
      ctrl_q.irq_en <= bpwm_pkg::CTRL_RST[bpwm_pkg::IEN_BIT];
      ctrl_q.timebase <= bpwm_pkg::CTRL_RST[bpwm_pkg::TB_LSB +: 8];
      ctrl_q.incr <= bpwm_pkg::CTRL_RST[bpwm_pkg::INC_LSB +: 8];
    end else if (wr_ctrl) begin
      ctrl_q.enable <= pwdata[bpwm_pkg::EN_BIT];
      ctrl_q.polarity <= pwdata[bpwm_pkg::POL_BIT];
      ctrl_q.irq_en <= pwdata[bpwm_pkg::IEN_BIT];
      ctrl_q.timebase <= pwdata[bpwm_pkg::TB_LSB +: 8];
      ctrl_q.incr <= pwdata[bpwm_pkg::INC_LSB +: 8];
    end
  end

  // Remaining count: the hardware step outranks a stray software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q.count <= bpwm_pkg::CTRL_RST[bpwm_pkg::CNT_LSB +: 8];
    end else if (inc_ev) begin
      ctrl_q.count <= ctrl_q.count - 8'h01;
    end else if (wr_ctrl) begin
      ctrl_q.count <= pwdata[bpwm_pkg::CNT_LSB +: 8];
    end
  end

  // Start bit: software sets it, completion clears it and wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q.start <= bpwm_pkg::CTRL_RST[bpwm_pkg::START_BIT];
    end else if (done_ev) begin
      ctrl_q.start <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_q.start <= pwdata[bpwm_pkg::START_BIT];
    end
  end

  // Sticky status: a completion in the clearing cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q.status <= bpwm_pkg::CTRL_RST[bpwm_pkg::STAT_BIT];
    end else if (done_ev && ctrl_q.irq_en) begin
      ctrl_q.status <= 1'b1;
    end else if (wr_ctrl && pwdata[bpwm_pkg::STAT_BIT]) begin
      ctrl_q.status <= 1'b0;
    end
  end

  // Period and duty; a software duty write outranks a step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_q <= bpwm_pkg::PWM_RST[bpwm_pkg::PER_LSB +: 16];
      duty_q <= bpwm_pkg::PWM_RST[bpwm_pkg::DUTY_LSB +: 16];
    end else if (wr_pwm) begin
      period_q <= pwdata[bpwm_pkg::PER_LSB +: 16];
      duty_q <= pwdata[bpwm_pkg::DUTY_LSB +: 16];
    end else if (inc_ev) begin
      duty_q <= stepped;
    end
  end

  // Sequencer: idle, counting vblanks, one-cycle end gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= bpwm_pkg::PH_IDLE;
      vb_cnt_q <= '0;
    end else begin
      unique case (state_q)
        bpwm_pkg::PH_IDLE: begin
          vb_cnt_q <= '0;
          // Invalid zero time base or count never starts a run
          if (ctrl_q.start && ctrl_q.count != 8'h00 && ctrl_q.timebase != 8'h00) begin
            state_q <= bpwm_pkg::PH_WAIT;
          end
        end
        bpwm_pkg::PH_WAIT: begin
          if (done_ev) begin
            state_q <= bpwm_pkg::PH_END;
            vb_cnt_q <= '0;
          end else if (!ctrl_q.start) begin
            state_q <= bpwm_pkg::PH_IDLE; // Software abort
          end else if (inc_ev) begin
            vb_cnt_q <= '0;
          end else if (vb_edge) begin
            vb_cnt_q <= vb_cnt_q + 8'h01;
          end
        end
        bpwm_pkg::PH_END: begin
          // Gap lets the cleared start bit settle before idle looks again
          state_q <= bpwm_pkg::PH_IDLE;
        end
        default: begin
          state_q <= bpwm_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // Disabled for two cycles means the raw level is low
  AST_DISABLED_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q.enable [*2] |-> !raw)
    else $error("raw output high while disabled");

  // Output level is the raw level turned by last cycle's polarity
  AST_POLARITY: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (backlight_pwm == (raw ^ $past(ctrl_q.polarity))))
    else $error("polarity not applied to output");

  // Zero duty in force keeps the output inactive
  AST_DUTY_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (duty_live == 16'h0000) |=> !raw)
    else $error("output active with zero duty");

  // Duty in force changes only at a cycle boundary while running
  AST_SHADOW_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.enable && !wrap) |=> $stable(duty_live))
    else $error("duty changed inside a cycle");

  // Each step lowers the remaining count by one
  AST_COUNT_DEC: assert property (@(posedge pclk) disable iff (!presetn)
    inc_ev |=> (ctrl_q.count == $past(ctrl_q.count) - 8'h01))
    else $error("count not decremented on step");

  // Each step sets duty to the clamped sum unless software wrote it
  AST_DUTY_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    (inc_ev && !wr_pwm) |=> (duty_q == $past(stepped)))
    else $error("duty not stepped");

  // Completion clears start and leaves the sequencer within two cycles
  AST_START_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    done_ev |=> !ctrl_q.start ##1 (state_q == bpwm_pkg::PH_IDLE))
    else $error("start not cleared at completion");

  // Enabled completion raises status and the interrupt line
  AST_STATUS_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (done_ev && ctrl_q.irq_en) |=> (ctrl_q.status && phase_in_irq))
    else $error("completion did not raise status");

  // Masked completion leaves a clear status clear
  AST_NO_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (done_ev && !ctrl_q.irq_en && !ctrl_q.status && !wr_ctrl) |=> !phase_in_irq)
    else $error("masked completion raised status");

  // Writing one clears status unless a completion lands together
  AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ctrl && pwdata[bpwm_pkg::STAT_BIT] && !done_ev) |=> !ctrl_q.status)
    else $error("status not cleared by write one");

  // Remaining count moves only on a step or a control write
  AST_COUNT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!inc_ev && !wr_ctrl) |=> $stable(ctrl_q.count))
    else $error("count changed with no step or write");

  // Duty moves only on a step or a period and duty write
  AST_DUTY_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!inc_ev && !wr_pwm) |=> $stable(duty_q))
    else $error("duty changed with no step or write");

  // A step never leaves the duty above the period
  AST_STEP_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
    (inc_ev && !wr_pwm) |=> (duty_q <= period_q))
    else $error("stepped duty above period");

  // Start stays set until completion or a software write
  AST_START_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.start && !done_ev && !wr_ctrl) |=> ctrl_q.start)
    else $error("start dropped before completion");

  // Status stays set until software writes a one to it
  AST_STATUS_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.status && !(wr_ctrl && pwdata[bpwm_pkg::STAT_BIT])) |=> ctrl_q.status)
    else $error("status lost without a clear");

  // Status rises only on an enabled completion
  AST_STATUS_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q.status && !(done_ev && ctrl_q.irq_en)) |=> !ctrl_q.status)
    else $error("status set without enabled completion");

  // A valid start moves the idle sequencer into the run
  AST_RUN_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == bpwm_pkg::PH_IDLE && ctrl_q.start && ctrl_q.count != 8'h00 && ctrl_q.timebase != 8'h00)
    |=> (state_q == bpwm_pkg::PH_WAIT))
    else $error("valid start did not begin a run");

  // The final step leaves no count remaining
  AST_DONE_EMPTY: assert property (@(posedge pclk) disable iff (!presetn)
    done_ev |=> (ctrl_q.count == 8'h00))
    else $error("count left after final step");

  // The blank tally restarts while the sequencer is idle
  AST_IDLE_TALLY: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == bpwm_pkg::PH_IDLE) |=> (vb_cnt_q == 8'h00))
    else $error("blank tally kept while idle");

  // A control read returns the live count of its setup cycle
  AST_READ_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_ctrl) |=> (prdata[bpwm_pkg::CNT_LSB +: 8] == $past(ctrl_q.count)))
    else $error("read count differs from live count");

  // A period and duty read returns both fields of its setup cycle
  AST_READ_PWM: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_pwm) |=> (prdata == {$past(period_q), $past(duty_q)}))
    else $error("read period and duty differ from registers");
endmodule
`default_nettype wire

// ==== bl_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Panel backlight input: tallies the clocks during which the drive line is high
module bl_panel_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic drive,
  output logic [31:0] hi_count
);
  // Free-running tally; the bench takes differences, so no clear is needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_count <= 32'h0000_0000;
    end else if (drive) begin
      hi_count <= hi_count + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// ==== backlight_pwm_phase_in_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the backlight modulator
module backlight_pwm_phase_in_tb;
  logic pclk = 1'b0; // Bus clock, 40 ns period
  logic presetn = 1'b0; // Held low for 20 cycles
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [19:0] paddr = 20'h0_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic vblank = 1'b0; // Frame blank level, rising edges are events
  logic low_power_idle_clock = 1'b0; // Time-base source select
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic backlight_pwm;
  logic phase_in_irq;
  logic [31:0] hi_count; // Partner's tally of high clocks
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [31:0] r;
  logic e;
  logic [15:0] per;
  logic [15:0] duty;
  logic en;
  logic pol;
  logic lp;
  int dv;

  always #20 pclk = ~pclk;

  backlight_pwm_phase_in uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vblank(vblank), .low_power_idle_clock(low_power_idle_clock),
    .backlight_pwm(backlight_pwm), .phase_in_irq(phase_in_irq));

  bl_panel_model panel (.pclk(pclk), .presetn(presetn), .drive(backlight_pwm), .hi_count(hi_count));

  // Ends the run; shared by the main sequence and the hang guard
  task results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard, well above the at most roughly 37k cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      results();
    end
  end

  // Single comparison point, four-state exact
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; an idle edge first keeps release and next setup apart
  task apb(input logic w, input logic [19:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait states are the slave's business; only the hang guard ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // A number of frame blank pulses
  task vb(input int n);
    repeat (n) begin
      @(posedge pclk);
      vblank <= 1'b1;
      repeat (3) @(posedge pclk);
      vblank <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  // High clocks seen by the panel over a window of n clocks
  task measure(input int n, output logic [31:0] d);
    logic [31:0] a;
    @(negedge pclk);
    a = hi_count;
    repeat (n) @(negedge pclk);
    d = hi_count - a;
  endtask

  // High clocks expected over n whole cycles; disabled active-low sits high
  function automatic logic [31:0] exp_hi(logic [15:0] p, logic [15:0] du, logic ena, logic po, int di, int n);
    logic [31:0] a;
    a = ena ? 32'(du) : 32'h0000_0000;
    if (po) begin
      a = 32'(p) - a;
    end
    return a * 32'(di) * 32'(n);
  endfunction

  initial begin
    void'($urandom(6));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, bpwm_pkg::CTRL_OFS, 32'h0000_0000);
    chk("ctrl reset", bpwm_pkg::CTRL_RST, r);
    apb(1'b0, bpwm_pkg::PWM_OFS, 32'h0000_0000);
    chk("pwm reset", bpwm_pkg::PWM_RST, r);
    apb(1'b0, 20'h6_1358, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    // Random period and duty, with zero, full, and both disabled levels forced
    for (int i = 0; i < 8; i++) begin
      per = 16'($urandom_range(1, 6));
      duty = (i == 0) ? 16'h0000 : (i == 1) ? per : 16'($urandom_range(0, 32'(per)));
      en = (i != 2 && i != 3);
      pol = (i == 3) ? 1'b1 : (i == 2) ? 1'b0 : 1'($urandom_range(0, 1));
      lp = 1'($urandom_range(0, 1));
      dv = lp ? bpwm_pkg::LP_DIV : bpwm_pkg::CORE_DIV;
      low_power_idle_clock <= lp;
      apb(1'b1, bpwm_pkg::PWM_OFS, {per, duty});
      apb(1'b1, bpwm_pkg::CTRL_OFS, {en, 2'b00, pol, 28'h000_0000});
      repeat (2 * 32'(per) * dv + 8) @(posedge pclk);
      measure(32'(per) * dv * 4, r);
      chk("high clocks", exp_hi(per, duty, en, pol, dv, 4), r);
    end
    // Phase-in: time base 2, three steps of +1, interrupt enabled
    low_power_idle_clock <= 1'b1;
    apb(1'b1, bpwm_pkg::PWM_OFS, 32'h0008_0002);
    apb(1'b1, bpwm_pkg::CTRL_OFS, 32'h8302_0301);
    vb(2);
    apb(1'b0, bpwm_pkg::CTRL_OFS, 32'h0000_0000);
    chk("ctrl mid run", 32'h8302_0201, r);
    vb(4);
    apb(1'b0, bpwm_pkg::CTRL_OFS, 32'h0000_0000);
    chk("ctrl done", 32'h8502_0001, r);
    chk("irq set", 32'h0000_0001, {31'h0, phase_in_irq});
    apb(1'b0, bpwm_pkg::PWM_OFS, 32'h0000_0000);
    chk("stepped duty", 32'h0008_0005, r);
    apb(1'b1, bpwm_pkg::CTRL_OFS, 32'h8100_0001);
    apb(1'b0, bpwm_pkg::CTRL_OFS, 32'h0000_0000);
    chk("status kept", 32'h8500_0001, r);
    apb(1'b1, bpwm_pkg::CTRL_OFS, 32'h8400_0001);
    apb(1'b0, bpwm_pkg::CTRL_OFS, 32'h0000_0000);
    chk("status cleared", 32'h8000_0001, r);
    chk("irq clear", 32'h0000_0000, {31'h0, phase_in_irq});
    // Second run: negative step, interrupt disabled
    apb(1'b1, bpwm_pkg::CTRL_OFS, 32'h8201_02ff);
    vb(3);
    apb(1'b0, bpwm_pkg::CTRL_OFS, 32'h0000_0000);
    chk("ctrl no irq", 32'h8001_00ff, r);
    apb(1'b0, bpwm_pkg::PWM_OFS, 32'h0000_0000);
    chk("down duty", 32'h0008_0003, r);
    // Large step clamps at the period
    apb(1'b1, bpwm_pkg::CTRL_OFS, 32'h8201_017f);
    vb(1);
    apb(1'b0, bpwm_pkg::CTRL_OFS, 32'h0000_0000);
    chk("ctrl clamp run", 32'h8001_007f, r);
    apb(1'b0, bpwm_pkg::PWM_OFS, 32'h0000_0000);
    chk("clamped duty", 32'h0008_0008, r);
    // Run cut short by clearing start: later blanks do not step
    apb(1'b1, bpwm_pkg::CTRL_OFS, 32'h8201_03ff);
    vb(1);
    apb(1'b1, bpwm_pkg::CTRL_OFS, 32'h8001_02ff);
    vb(1);
    apb(1'b0, bpwm_pkg::CTRL_OFS, 32'h0000_0000);
    chk("ctrl aborted", 32'h8001_02ff, r);
    apb(1'b0, bpwm_pkg::PWM_OFS, 32'h0000_0000);
    chk("held duty", 32'h0008_0007, r);
    results();
  end
endmodule
`default_nettype wire
